// file: verilog/sem_host_pkg.sv
// Package for the semaphore host controller: constants, commands, carriers
package sem_host_pkg;
   localparam int FLAG_COUNT = 8;
   localparam int INDEX_W = 3;
   localparam int DATA_W = 18;
   localparam int ADDR_W = 15;
   localparam int REQ_BIT = 0;
   localparam logic REQ_TAKE = 1'b0;
   localparam logic REQ_FREE = 1'b1;
   // Pin timing figures in ns and derived cycle counts at 250 MHz
   localparam int CLK_PERIOD_NS = 4;
   localparam int SETUP_NS = 8;
   localparam int STROBE_NS = 20;
   localparam int GAP_NS = 8;
   localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int GAP_CYC = (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 8;
   localparam logic [CNT_W-1:0] CNT_RESET = 8'h00;

   typedef enum logic [1:0] {
      CMD_ACQUIRE = 2'h0,
      CMD_RELEASE = 2'h1,
      CMD_WITHDRAW = 2'h2,
      CMD_INIT = 2'h3
   } cmd_t;

   typedef struct packed {
      cmd_t cmd;
      logic [INDEX_W-1:0] index;
      logic retry;
   } req_t;

   typedef struct packed {
      logic done;
      logic granted;
   } rsp_t;

   // Pins of one port in semaphore space
   typedef struct packed {
      logic token_select_n;
      logic chip_en_n;
      logic wr_n;
      logic out_en_n;
      logic [INDEX_W-1:0] flag_index_bits;
      logic [DATA_W-1:0] data_out;
      logic data_oe;
   } pins_t;
endpackage : sem_host_pkg

// file: verilog/sem_cycle.sv
// One semaphore access cycle on the port pins, write or read
`timescale 1ns/1ns
`default_nettype none
module sem_cycle
   import sem_host_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic start_i,
   input wire logic write_i,
   input wire logic wr_value_i,
   input wire logic [INDEX_W-1:0] index_i,
   input wire logic rd_bit_i,
   output logic busy_o,
   output logic done_o,
   output logic rd_value_o,
   output pins_t pins_o
);
   typedef enum logic [3:0] {
      C_IDLE = 4'h1,
      C_SETUP = 4'h2,
      C_STROBE = 4'h4,
      C_GAP = 4'h8
   } cyc_state_t;

   cyc_state_t state;
   logic [CNT_W-1:0] cnt;
   logic is_write;

   function automatic logic [CNT_W-1:0] cycles(input int n);
      cycles = CNT_W'(n - 1);
   endfunction

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         state <= C_IDLE;
         cnt <= CNT_RESET;
         is_write <= 1'b0;
         done_o <= 1'b0;
         rd_value_o <= 1'b1;
         pins_o <= '{token_select_n: 1'b1, chip_en_n: 1'b1, wr_n: 1'b1,
                     out_en_n: 1'b1, default: '0};
      end else begin
         done_o <= 1'b0;
         case (state)
            C_IDLE: begin
               if (start_i) begin
                  is_write <= write_i;
                  pins_o.token_select_n <= 1'b0;
                  pins_o.flag_index_bits <= index_i;
                  // Only the low bit carries the request
                  pins_o.data_out <= DATA_W'({31'h0, wr_value_i});
                  pins_o.data_oe <= write_i;
                  cnt <= cycles(SETUP_CYC);
                  state <= C_SETUP;
               end
            end
            C_SETUP: begin
               if (cnt == CNT_RESET) begin
                  pins_o.wr_n <= !is_write;
                  pins_o.out_en_n <= is_write;
                  cnt <= cycles(STROBE_CYC);
                  state <= C_STROBE;
               end else begin
                  cnt <= cnt - 8'h01;
               end
            end
            C_STROBE: begin
               if (cnt == CNT_RESET) begin
                  // Token select and both strobes rise so the next read relatches the flag
                  if (!is_write) rd_value_o <= rd_bit_i;
                  pins_o.wr_n <= 1'b1;
                  pins_o.out_en_n <= 1'b1;
                  pins_o.token_select_n <= 1'b1;
                  pins_o.data_oe <= 1'b0;
                  cnt <= cycles(GAP_CYC);
                  state <= C_GAP;
               end else begin
                  cnt <= cnt - 8'h01;
               end
            end
            C_GAP: begin
               if (cnt == CNT_RESET) begin
                  done_o <= 1'b1;
                  state <= C_IDLE;
               end else begin
                  cnt <= cnt - 8'h01;
               end
            end
            default: state <= C_IDLE;
         endcase
      end
   end

   assign busy_o = (state != C_IDLE);
endmodule // sem_cycle
`default_nettype wire

// file: verilog/sem_host.sv
// Host controller that claims and frees semaphore tokens on one RAM port
`timescale 1ns/1ns
`default_nettype none
module sem_host
   import sem_host_pkg::*;
#(
   parameter int FLAGS = FLAG_COUNT
)
(
   input wire logic CORE_CLK_I,
   input wire logic RST_N_I,
   input wire logic REQ_VALID_I,
   input wire req_t REQ_I,
   input wire logic [DATA_W-1:0] DATA_I,
   output logic REQ_READY_O,
   output rsp_t RSP_O,
   output logic TOKEN_SELECT_N_O,
   output logic CHIP_EN_N_O,
   output logic WR_N_O,
   output logic OUT_EN_N_O,
   output logic [ADDR_W-1:0] ADDR_O,
   output logic [DATA_W-1:0] DATA_O,
   output logic DATA_OE_O,
   output logic [FLAGS-1:0] OWNED_O
);
   typedef enum logic [5:0] {
      S_IDLE = 6'h01,
      S_WRITE = 6'h02,
      S_READ = 6'h04,
      S_CHECK = 6'h08,
      S_WAIT = 6'h10,
      S_REPLY = 6'h20
   } host_state_t;

   host_state_t state;
   req_t cur;
   logic [INDEX_W-1:0] init_index;
   logic data_meta;
   logic data_sync;
   logic cyc_start;
   logic cyc_write;
   logic cyc_value;
   logic cyc_busy;
   logic cyc_done;
   logic cyc_rd;
   pins_t cyc_pins;
   logic granted;

   // -------------------------------------------------------------
   // Pin input synchroniser
   // -------------------------------------------------------------
   // Only bit zero is read; the flag is spread over every data pin
   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         data_meta <= 1'b1;
         data_sync <= 1'b1;
      end else begin
         data_meta <= DATA_I[REQ_BIT];
         data_sync <= data_meta;
      end
   end

   // -------------------------------------------------------------
   // Pin cycle engine
   // -------------------------------------------------------------
   // Init walks the index; otherwise the command's own flag
   sem_cycle u_cycle (
      .clk_i(CORE_CLK_I),
      .rst_n_i(RST_N_I),
      .start_i(cyc_start),
      .write_i(cyc_write),
      .wr_value_i(cyc_value),
      .index_i((cur.cmd == CMD_INIT) ? init_index : cur.index),
      .rd_bit_i(data_sync),
      .busy_o(cyc_busy),
      .done_o(cyc_done),
      .rd_value_o(cyc_rd),
      .pins_o(cyc_pins)
   );

   // -------------------------------------------------------------
   // Command sequencer
   // -------------------------------------------------------------
   // One command at a time; a new one is taken only in idle
   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         state <= S_IDLE;
         cur <= '0;
         init_index <= '0;
         cyc_start <= 1'b0;
         cyc_write <= 1'b0;
         cyc_value <= REQ_FREE;
         granted <= 1'b0;
      end else begin
         cyc_start <= 1'b0;
         case (state)
            S_IDLE: begin
               if (REQ_VALID_I) begin
                  cur <= REQ_I;
                  init_index <= '0;
                  granted <= 1'b0;
                  cyc_start <= 1'b1;
                  cyc_write <= 1'b1;
                  // Acquire writes zero first, then reads back
                  cyc_value <= (REQ_I.cmd == CMD_ACQUIRE) ? REQ_TAKE
                                                          : REQ_FREE;
                  state <= S_WRITE;
               end
            end
            S_WRITE: begin
               if (cyc_done) begin
                  if (cur.cmd == CMD_ACQUIRE) begin
                     cyc_start <= 1'b1;
                     cyc_write <= 1'b0;
                     state <= S_READ;
                  end else if (cur.cmd == CMD_INIT &&
                               init_index != INDEX_W'(FLAGS - 1)) begin
                     init_index <= init_index + 3'h1;
                     cyc_start <= 1'b1;
                  end else begin
                     state <= S_REPLY;
                  end
               end
            end
            S_READ: begin
               if (cyc_done) state <= S_CHECK;
            end
            S_CHECK: begin
               // Zero read back means this port owns the token
               if (cyc_rd == REQ_TAKE) begin
                  granted <= 1'b1;
                  state <= S_REPLY;
               end else if (cur.retry) begin
                  // Reread until the far port frees the token
                  cyc_start <= 1'b1;
                  cyc_write <= 1'b0;
                  state <= S_READ;
               end else begin
                  // Refused without retry: withdraw the pending zero
                  cyc_start <= 1'b1;
                  cyc_write <= 1'b1;
                  cyc_value <= REQ_FREE;
                  state <= S_WAIT;
               end
            end
            S_WAIT: begin
               if (cyc_done) state <= S_REPLY;
            end
            S_REPLY: state <= S_IDLE;
            default: state <= S_IDLE;
         endcase
      end
   end

   // -------------------------------------------------------------
   // Ownership record and replies
   // -------------------------------------------------------------
   // Host's own view of the tokens, updated at the reply only
   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         OWNED_O <= '0;
         RSP_O <= '0;
         REQ_READY_O <= 1'b0;
      end else begin
         RSP_O.done <= (state == S_REPLY);
         RSP_O.granted <= (state == S_REPLY) && granted;
         REQ_READY_O <= (state == S_IDLE) && !REQ_VALID_I && !cyc_busy;
         if (state == S_REPLY) begin
            case (cur.cmd)
               CMD_ACQUIRE: OWNED_O[cur.index] <= granted;
               CMD_RELEASE,
               CMD_WITHDRAW: OWNED_O[cur.index] <= 1'b0;
               CMD_INIT: OWNED_O <= '0;
               default: OWNED_O <= OWNED_O;
            endcase
         end
      end
   end

   // -------------------------------------------------------------
   // Pin outputs, registered
   // -------------------------------------------------------------
   // The array select stays off; only semaphore space is used
   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         TOKEN_SELECT_N_O <= 1'b1;
         CHIP_EN_N_O <= 1'b1;
         WR_N_O <= 1'b1;
         OUT_EN_N_O <= 1'b1;
         ADDR_O <= '0;
         DATA_O <= '0;
         DATA_OE_O <= 1'b0;
      end else begin
         TOKEN_SELECT_N_O <= cyc_pins.token_select_n;
         CHIP_EN_N_O <= cyc_pins.chip_en_n;
         WR_N_O <= cyc_pins.wr_n;
         OUT_EN_N_O <= cyc_pins.out_en_n;
         ADDR_O <= ADDR_W'(cyc_pins.flag_index_bits);
         DATA_O <= cyc_pins.data_out;
         DATA_OE_O <= cyc_pins.data_oe;
      end
   end
endmodule // sem_host
`default_nettype wire

// file: testbench/sem_host_sva.sv
// Pin-level checks on the semaphore host controller
`timescale 1ns/1ns
`default_nettype none
module sem_host_sva
   import sem_host_pkg::*;
#(
   parameter int FLAGS = FLAG_COUNT
)
(
   input wire logic CORE_CLK_I,
   input wire logic RST_N_I,
   input wire logic REQ_VALID_I,
   input wire req_t REQ_I,
   input wire logic [DATA_W-1:0] DATA_I,
   input wire logic REQ_READY_O,
   input wire rsp_t RSP_O,
   input wire logic TOKEN_SELECT_N_O,
   input wire logic CHIP_EN_N_O,
   input wire logic WR_N_O,
   input wire logic OUT_EN_N_O,
   input wire logic [ADDR_W-1:0] ADDR_O,
   input wire logic [DATA_W-1:0] DATA_O,
   input wire logic DATA_OE_O,
   input wire logic [FLAGS-1:0] OWNED_O
);
   default clocking cb @(posedge CORE_CLK_I);
   endclocking
   default disable iff (!RST_N_I);
   logic pend;
   logic [INDEX_W-1:0] pidx;
   // ----------------------------------------
   // Whether the last write was a take request, and its index
   // ----------------------------------------
   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         pend <= 1'b0;
         pidx <= '0;
      end else if ($fell(WR_N_O)) begin
         pend <= !DATA_O[REQ_BIT];
         pidx <= ADDR_O[INDEX_W-1:0];
      end
   end
   a_ram_never_on: assert property (CHIP_EN_N_O)
      else $error("array select active");
   a_addr_upper_zero: assert property (!TOKEN_SELECT_N_O |->
      ADDR_O[ADDR_W-1:INDEX_W] == '0) else $error("upper address set");
   a_write_in_sel: assert property (!WR_N_O |->
      !TOKEN_SELECT_N_O && DATA_OE_O && OUT_EN_N_O) else $error("bad write");
   a_data_bit_only: assert property (!WR_N_O |->
      DATA_O[DATA_W-1:1] == '0) else $error("upper data set");
   a_read_no_drive: assert property (!OUT_EN_N_O |->
      !TOKEN_SELECT_N_O && !DATA_OE_O) else $error("bad read");
   a_write_strobe_len: assert property ($fell(WR_N_O) |->
      !WR_N_O [*5] ##1 WR_N_O) else $error("strobe length");
   a_read_after_write: assert property ($fell(OUT_EN_N_O) |->
      pend && ADDR_O[INDEX_W-1:0] == pidx) else $error("read first");
   a_read_strobe_held: assert property ($fell(OUT_EN_N_O) |->
      !OUT_EN_N_O [*5]) else $error("read length");
   a_sel_between_reads: assert property ($fell(OUT_EN_N_O) |->
      $past(TOKEN_SELECT_N_O, 3) || $past(TOKEN_SELECT_N_O, 4))
      else $error("select held across reads");
   a_grant_owns: assert property (RSP_O.granted |->
      RSP_O.done ##[0:1] OWNED_O != '0) else $error("grant not owned");
   a_ready_idle_pins: assert property (REQ_READY_O |->
      TOKEN_SELECT_N_O && WR_N_O && OUT_EN_N_O) else $error("ready busy");
   a_valid_not_ready: assert property (REQ_VALID_I |=>
      !REQ_READY_O) else $error("ready with command");
   c_grant: cover property (RSP_O.granted);
   c_refused: cover property (RSP_O.done && !RSP_O.granted);
   c_free_write: cover property ($fell(WR_N_O) && DATA_O[REQ_BIT]);
endmodule // sem_host_sva
`default_nettype wire

// file: testbench/sem_dev_model.sv
// Behavioural model of the eight token flags seen from two ports
`timescale 1ns/1ns
`default_nettype none
module sem_dev_model
   import sem_host_pkg::*;
(
   input wire logic sel_n_i,
   input wire logic wr_n_i,
   input wire logic oe_n_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [DATA_W-1:0] data_i,
   input wire logic data_oe_i,
   output logic [DATA_W-1:0] data_o
);
   // Power-up junk: host side starts holding every token
   logic [7:0] lq = 8'h00;
   logic [7:0] rq = 8'hFF;
   logic [7:0] own_l = 8'hFF;
   logic [7:0] own_r = 8'h00;
   logic [DATA_W-1:0] rd = '0;
   wire act_n = sel_n_i | oe_n_i;
   task automatic settle();
      for (int i = 0; i < FLAG_COUNT; i++) begin
         if (own_l[i] && lq[i]) own_l[i] = 1'b0;
         if (own_r[i] && rq[i]) own_r[i] = 1'b0;
         if (!own_l[i] && !own_r[i]) begin
            if (!lq[i]) own_l[i] = 1'b1;
            else if (!rq[i]) own_r[i] = 1'b1;
         end
      end
   endtask
   task automatic r_write(input int i, input logic v);
      rq[i] = v;
      settle();
   endtask
   always @(negedge wr_n_i) begin
      if (!sel_n_i) begin
         lq[addr_i[INDEX_W-1:0]] = data_i[REQ_BIT];
         settle();
      end
   end
   always @(negedge act_n) begin
      rd = {DATA_W{!own_l[addr_i[INDEX_W-1:0]]}};
   end
   // Released bus shows the inverse of the last read
   assign data_o = data_oe_i ? data_i : (act_n ? ~rd : rd);
endmodule // sem_dev_model
`default_nettype wire

// file: testbench/test_sem_host.sv
// Self-checking bench for the semaphore host controller
`timescale 1ns/1ns
`default_nettype none
module test_sem_host
   import sem_host_pkg::*;
;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic valid = 1'b0;
   req_t req = '0;
   wire [DATA_W-1:0] din;
   logic rdy, sel_n, ce_n, wr_n, oe_n, doe, got;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] dout;
   logic [FLAG_COUNT-1:0] owned;
   rsp_t rsp;
   int fail_count = 0;
   int n_compared = 0;
   sem_host #(.FLAGS(FLAG_COUNT)) dut (.CORE_CLK_I(clk), .RST_N_I(rst_n),
      .REQ_VALID_I(valid), .REQ_I(req), .DATA_I(din), .REQ_READY_O(rdy),
      .RSP_O(rsp), .TOKEN_SELECT_N_O(sel_n), .CHIP_EN_N_O(ce_n),
      .WR_N_O(wr_n), .OUT_EN_N_O(oe_n), .ADDR_O(addr), .DATA_O(dout),
      .DATA_OE_O(doe), .OWNED_O(owned));
   sem_dev_model dev (.sel_n_i(sel_n), .wr_n_i(wr_n), .oe_n_i(oe_n),
      .addr_i(addr), .data_i(dout), .data_oe_i(doe), .data_o(din));
   initial begin
      forever #2 clk = ~clk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic logic [31:0] flag_bit(input int i);
      flag_bit = 32'h1 << i;
   endfunction
   task automatic finish_test();
      $display("compared %0d failed %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic run(input cmd_t c, input int i, input logic rt);
      int n;
      @(posedge clk);
      #1;
      valid = 1'b1;
      req = '{c, i[INDEX_W-1:0], rt};
      for (n = 0; n < 4000 && rsp.done !== 1'b1; n++) begin
         @(posedge clk);
         #1;
      end
      got = rsp.granted;
      valid = 1'b0;
      if (rsp.done !== 1'b1) begin
         fail_count++;
         finish_test();
      end
   endtask
   initial begin
      int i;
      void'($urandom(55643));
      repeat (2) @(posedge clk);
      #1;
      check({sel_n, ce_n, wr_n, oe_n, doe}, 32'h1E);
      check(owned, 32'h0);
      rst_n = 1'b1;
      run(CMD_INIT, 0, 1'b0);
      check(dev.lq, 32'hFF);
      check(dev.own_l, 32'h0);
      @(posedge clk);
      #1;
      check(rdy, 32'h1);
      $display("init test done");
      for (int k = 0; k < 4; k++) begin
         i = $urandom % FLAG_COUNT;
         run(CMD_ACQUIRE, i, 1'b0);
         check(got, 32'h1);
         check(owned, flag_bit(i));
         dev.r_write(i, 1'b0);
         check(dev.own_r[i], 32'h0);
         run(CMD_RELEASE, i, 1'b0);
         check(got, 32'h0);
         check(owned, 32'h0);
         check(dev.own_r[i], 32'h1);
         check(dev.own_l & dev.own_r, 32'h0);
         run(CMD_ACQUIRE, i, 1'b0);
         check(got, 32'h0);
         check(dev.lq[i], 32'h1);
         fork
            #(200 + $urandom % 400) dev.r_write(i, 1'b1);
         join_none
         run(CMD_ACQUIRE, i, 1'b1);
         check(got, 32'h1);
         run(CMD_WITHDRAW, i, 1'b0);
         check(dev.own_l[i], 32'h0);
         check(owned, 32'h0);
         $display("token test %0d done on flag %0d", k, i);
      end
      finish_test();
   end
endmodule // test_sem_host
bind sem_host sem_host_sva #(.FLAGS(FLAGS)) chk (.CORE_CLK_I(CORE_CLK_I),
   .RST_N_I(RST_N_I), .REQ_VALID_I(REQ_VALID_I), .REQ_I(REQ_I),
   .DATA_I(DATA_I), .REQ_READY_O(REQ_READY_O), .RSP_O(RSP_O),
   .TOKEN_SELECT_N_O(TOKEN_SELECT_N_O), .CHIP_EN_N_O(CHIP_EN_N_O),
   .WR_N_O(WR_N_O), .OUT_EN_N_O(OUT_EN_N_O), .ADDR_O(ADDR_O),
   .DATA_O(DATA_O), .DATA_OE_O(DATA_OE_O), .OWNED_O(OWNED_O));
`default_nettype wire
